// ---- shared/ftc_pkg.sv ----
// Package with register map, field layout, reset values and timing counts.
package ftc_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FLASH_A = 4'h1;
  localparam logic [3:0] ADDR_FLASH_B = 4'h2;
  localparam logic [3:0] ADDR_LAMP_A = 4'h3;
  localparam logic [3:0] ADDR_LAMP_B = 4'h4;
  localparam logic [3:0] ADDR_GATED = 4'h5;
  localparam logic [3:0] ADDR_RAMP = 4'h6;
  localparam logic [3:0] ADDR_FTIMER = 4'h7;
  localparam logic [3:0] ADDR_LTIMER = 4'h8;
  localparam logic [3:0] ADDR_DROOP = 4'h9;
  localparam logic [3:0] ADDR_RADIO1 = 4'hA;
  localparam logic [3:0] ADDR_RADIO2 = 4'hB;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam logic [3:0] ADDR_LOG_A = 4'hD;
  localparam logic [3:0] ADDR_LOG_B = 4'hE;
  localparam logic [3:0] ADDR_LEVEL = 4'hF;
  // Control, lamp timer and status register bits.
  localparam int CTRL_FLASH_A = 0;
  localparam int CTRL_FLASH_B = 1;
  localparam int CTRL_LAMP_A = 2;
  localparam int CTRL_LAMP_B = 3;
  localparam int CTRL_GATED = 4;
  localparam int CTRL_PARALLEL = 5;
  localparam int LTIMER_DISABLE = 7;
  localparam int STATUS_DROOP = 0;
  localparam int STATUS_FTIMEOUT = 1;
  localparam int STATUS_LTIMEOUT = 2;
  // Reset values.
  localparam logic [7:0] RST_FLASH = 8'h3F;
  localparam logic [7:0] RST_LAMP = 8'h3F;
  localparam logic [7:0] RST_GATED = 8'h00;
  localparam logic [7:0] RST_RAMP = 8'h11;
  localparam logic [7:0] RST_FTIMER = 8'h0F;
  localparam logic [7:0] RST_LTIMER = 8'h00;
  localparam logic [7:0] RST_DROOP = 8'h10;
  localparam logic [7:0] RST_RADIO = 8'h1F;
  // Level codes: flash LSB 15.625mA (64 steps = 1000mA),
  // static lamp LSB 3.91mA (64 steps = 250mA), gated lamp 125mA LSB.
  localparam logic [7:0] FLASH_FULL = 8'h40;
  localparam logic [7:0] LAMP_FULL = 8'h40;
  localparam logic [7:0] GATED_STEP = 8'h08;
  // Timing: 100 MHz clock.
  localparam int CLK_MHZ = 100;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  localparam int FTIMER_LSB_US = 256;
  localparam int FTIMER_LSB_CYC = FTIMER_LSB_US * CLK_MHZ;
  localparam int LTIMER_LSB_US = 122900;
  localparam int LTIMER_LSB_CYC = LTIMER_LSB_US * CLK_MHZ;
  localparam int PWM_SLOTS = 32;
  typedef enum logic [1:0] {
    FT_ONESHOT,
    FT_MAXDUR,
    FT_PWM
  } ftc_ftmode_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ftc_bus_t;
  typedef struct packed {
    logic [7:0] levelA;
    logic [7:0] levelB;
    logic onA;
    logic onB;
  } ftc_drive_t;
endpackage

// ---- verilog/ftc_core.sv ----
// Flash and lamp current regulator control with ramps, timers, droop loop.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
module ftc_core #(
  parameter int FTIMER_LSB = ftc_pkg::FTIMER_LSB_CYC,
  parameter int LTIMER_LSB = ftc_pkg::LTIMER_LSB_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire ftc_pkg::ftc_bus_t bus,
  output logic [7:0] rdData,
  input wire logic flashTrigger,
  input wire logic lampTrigger,
  input wire logic radioLimitPrimary,
  input wire logic radioLimitSecondary,
  input wire logic inputLow,
  input wire logic inputRecovered,
  output ftc_pkg::ftc_drive_t drive
);
  logic [7:0] ctrl_r, flashA_r, flashB_r, lampA_r, lampB_r, gated_r;
  logic [7:0] ramp_r, ftimer_r, ltimer_r, droop_r, radio1_r, radio2_r;
  logic [7:0] status_r, logA_r, logB_r;
  logic [7:0] levelA_r, levelB_r, capA_r, capB_r;
  logic [9:0] tickCnt_r, ruDiv_r;
  logic [31:0] fCnt_r, lCnt_r, droopCnt_r;
  logic [4:0] pwmSlot_r;
  logic [7:0] pwmDiv_r;
  logic flashOn_r, lampOn_r, flashPrev_r, lampPrev_r, trigPrev_r;
  logic flashReq, lampReq, tick, droopTick, wrCtrl, anyOn, rampingUp;
  logic [7:0] tgtA, tgtB, limA, limB;

  function automatic logic [7:0] stepTo(input logic [7:0] cur,
                                        input logic [7:0] tgt,
                                        input logic [7:0] inc);
    if (cur < tgt)
      stepTo = (tgt - cur > inc) ? cur + inc : tgt;
    else if (cur > tgt)
      stepTo = (cur - tgt > inc) ? cur - inc : tgt;
    else
      stepTo = cur;
  endfunction

  function automatic logic [7:0] minOf(input logic [7:0] a,
                                       input logic [7:0] b);
    minOf = (a < b) ? a : b;
  endfunction

  // Register writes; timer expiry also clears enable bits.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r <= 8'h00;
      flashA_r <= ftc_pkg::RST_FLASH;
      flashB_r <= ftc_pkg::RST_FLASH;
      lampA_r <= ftc_pkg::RST_LAMP;
      lampB_r <= ftc_pkg::RST_LAMP;
      gated_r <= ftc_pkg::RST_GATED;
      ramp_r <= ftc_pkg::RST_RAMP;
      ftimer_r <= ftc_pkg::RST_FTIMER;
      ltimer_r <= ftc_pkg::RST_LTIMER;
      droop_r <= ftc_pkg::RST_DROOP;
      radio1_r <= ftc_pkg::RST_RADIO;
      radio2_r <= ftc_pkg::RST_RADIO;
    end else if (clkEn) begin
      if (bus.wr) begin
        unique case (bus.addr)
          ftc_pkg::ADDR_CTRL: ctrl_r <= bus.wdata;
          ftc_pkg::ADDR_FLASH_A: flashA_r <= bus.wdata;
          ftc_pkg::ADDR_FLASH_B: flashB_r <= bus.wdata;
          ftc_pkg::ADDR_LAMP_A: lampA_r <= bus.wdata;
          ftc_pkg::ADDR_LAMP_B: lampB_r <= bus.wdata;
          ftc_pkg::ADDR_GATED: gated_r <= bus.wdata;
          ftc_pkg::ADDR_RAMP: ramp_r <= bus.wdata;
          ftc_pkg::ADDR_FTIMER: ftimer_r <= bus.wdata;
          ftc_pkg::ADDR_LTIMER: ltimer_r <= bus.wdata;
          ftc_pkg::ADDR_DROOP: droop_r <= bus.wdata;
          ftc_pkg::ADDR_RADIO1: radio1_r <= bus.wdata;
          ftc_pkg::ADDR_RADIO2: radio2_r <= bus.wdata;
          default: ;
        endcase
      end
      // Expiry disables the mode; the ramp then runs down.
      if (flashPrev_r && !flashOn_r) begin
        ctrl_r[ftc_pkg::CTRL_FLASH_A] <= 1'b0;
        ctrl_r[ftc_pkg::CTRL_FLASH_B] <= 1'b0;
      end
      if (lampPrev_r && !lampOn_r) begin
        ctrl_r[ftc_pkg::CTRL_LAMP_A] <= 1'b0;
        ctrl_r[ftc_pkg::CTRL_LAMP_B] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n)
      rdData <= 8'h00;
    else if (clkEn && bus.rd) begin
      unique case (bus.addr)
        ftc_pkg::ADDR_CTRL: rdData <= ctrl_r;
        ftc_pkg::ADDR_FLASH_A: rdData <= flashA_r;
        ftc_pkg::ADDR_FLASH_B: rdData <= flashB_r;
        ftc_pkg::ADDR_LAMP_A: rdData <= lampA_r;
        ftc_pkg::ADDR_LAMP_B: rdData <= lampB_r;
        ftc_pkg::ADDR_GATED: rdData <= gated_r;
        ftc_pkg::ADDR_RAMP: rdData <= ramp_r;
        ftc_pkg::ADDR_FTIMER: rdData <= ftimer_r;
        ftc_pkg::ADDR_LTIMER: rdData <= ltimer_r;
        ftc_pkg::ADDR_DROOP: rdData <= droop_r;
        ftc_pkg::ADDR_RADIO1: rdData <= radio1_r;
        ftc_pkg::ADDR_RADIO2: rdData <= radio2_r;
        ftc_pkg::ADDR_STATUS: rdData <= status_r;
        ftc_pkg::ADDR_LOG_A: rdData <= logA_r;
        ftc_pkg::ADDR_LOG_B: rdData <= logB_r;
        default: rdData <= levelA_r;
      endcase
    end
  end

  assign wrCtrl = clkEn && bus.wr && bus.addr == ftc_pkg::ADDR_CTRL;
  // The logic trigger pins OR with the register enables.
  assign flashReq = flashTrigger || ctrl_r[ftc_pkg::CTRL_FLASH_A]
                    || ctrl_r[ftc_pkg::CTRL_FLASH_B];
  assign lampReq = lampTrigger || ctrl_r[ftc_pkg::CTRL_LAMP_A]
                   || ctrl_r[ftc_pkg::CTRL_LAMP_B];

  // Flash safety timer and mode state.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flashOn_r <= 1'b0;
      flashPrev_r <= 1'b0;
      trigPrev_r <= 1'b0;
      fCnt_r <= 32'h0;
    end else if (clkEn) begin
      flashPrev_r <= flashOn_r;
      trigPrev_r <= flashReq;
      if (!flashOn_r) begin
        fCnt_r <= 32'h0;
        if (flashReq && !trigPrev_r)
          flashOn_r <= 1'b1;
      end else begin
        fCnt_r <= fCnt_r + 32'h1;
        if (fCnt_r >= FTIMER_LSB * (32'(ftimer_r[5:0]) + 1))
          flashOn_r <= 1'b0;
        // Maximum-duration mode follows the trigger level.
        else if (ftimer_r[7:6] == 2'(ftc_pkg::FT_MAXDUR) && !flashReq)
          flashOn_r <= 1'b0;
        else if (ftimer_r[7:6] != 2'(ftc_pkg::FT_ONESHOT) && !flashReq)
          flashOn_r <= 1'b0;
        // A host write that drops every flash enable ends a one-shot flash
        // before expiry; a pin-started one-shot is left to its timer.
        else if (wrCtrl && (ctrl_r[ftc_pkg::CTRL_FLASH_A]
                 || ctrl_r[ftc_pkg::CTRL_FLASH_B])
                 && !bus.wdata[ftc_pkg::CTRL_FLASH_A]
                 && !bus.wdata[ftc_pkg::CTRL_FLASH_B])
          flashOn_r <= 1'b0;
      end
    end
  end

  // Lamp safety timer, follows the request level, with disable bit.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lampOn_r <= 1'b0;
      lampPrev_r <= 1'b0;
      lCnt_r <= 32'h0;
    end else if (clkEn) begin
      lampPrev_r <= lampOn_r;
      if (!lampReq) begin
        lampOn_r <= 1'b0;
        lCnt_r <= 32'h0;
      end else if (!lampOn_r && lCnt_r == 32'h0) begin
        lampOn_r <= 1'b1;
      end else if (lampOn_r && !ltimer_r[ftc_pkg::LTIMER_DISABLE]) begin
        lCnt_r <= lCnt_r + 32'h1;
        if (lCnt_r >= LTIMER_LSB * (32'(ltimer_r[6:0]) + 1))
          lampOn_r <= 1'b0;
      end
    end
  end

  // Internal ramp tick; ramp field sets ticks per step.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tickCnt_r <= 10'h0;
      ruDiv_r <= 10'h0;
    end else if (clkEn) begin
      tickCnt_r <= (tickCnt_r == 10'(ftc_pkg::TICK_CYC - 1)) ? 10'h0
                   : tickCnt_r + 10'h1;
      if (tickCnt_r == 10'(ftc_pkg::TICK_CYC - 1))
        ruDiv_r <= (ruDiv_r >= {6'h0, rampingUp ? ramp_r[3:0]
                    : ramp_r[7:4]}) ? 10'h0 : ruDiv_r + 10'h1;
    end
  end
  // Ramp time = programmed time x level/full: fixed time per code.
  assign tick = tickCnt_r == 10'(ftc_pkg::TICK_CYC - 1) && ruDiv_r == 10'h0;
  assign rampingUp = levelA_r < tgtA || levelB_r < tgtB;

  // Targets: flash outranks lamp; gated lamp sets DAC full scale.
  always_comb begin
    limA = capA_r;
    limB = capB_r;
    if (flashOn_r) begin
      // Primary mask wins while both are active.
      if (radioLimitPrimary) begin
        limA = minOf(limA, radio1_r);
        limB = minOf(limB, radio1_r);
      end else if (radioLimitSecondary) begin
        limA = minOf(limA, radio2_r);
        limB = minOf(limB, radio2_r);
      end
      tgtA = minOf(flashA_r, limA);
      tgtB = minOf(flashB_r, limB);
    end else if (lampOn_r && ctrl_r[ftc_pkg::CTRL_GATED]) begin
      tgtA = minOf(8'(gated_r[2:0]) * ftc_pkg::GATED_STEP, limA);
      tgtB = tgtA;
    end else if (lampOn_r) begin
      tgtA = minOf(lampA_r, limA);
      tgtB = minOf(lampB_r, limB);
    end else begin
      tgtA = 8'h00;
      tgtB = 8'h00;
    end
  end

  // Staircase ramp. Paralleled outputs double the step until either
  // output reaches its target. Masks cut straight to the cap.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      levelA_r <= 8'h00;
      levelB_r <= 8'h00;
    end else if (clkEn) begin
      if (levelA_r > tgtA && flashOn_r &&
          (radioLimitPrimary || radioLimitSecondary))
        levelA_r <= tgtA;
      else if (tick)
        levelA_r <= stepTo(levelA_r, tgtA, (ctrl_r[ftc_pkg::CTRL_PARALLEL]
                    && levelA_r != tgtA && levelB_r != tgtB) ? 8'h02
                    : 8'h01);
      if (levelB_r > tgtB && flashOn_r &&
          (radioLimitPrimary || radioLimitSecondary))
        levelB_r <= tgtB;
      else if (tick)
        levelB_r <= stepTo(levelB_r, tgtB, (ctrl_r[ftc_pkg::CTRL_PARALLEL]
                    && levelA_r != tgtA && levelB_r != tgtB) ? 8'h02
                    : 8'h01);
    end
  end

  // Droop loop: caps stepped per recheck interval.
  assign anyOn = flashOn_r || lampOn_r;
  assign droopTick = droopCnt_r >= ftc_pkg::TICK_CYC * 32'(droop_r[7:4]);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      droopCnt_r <= 32'h0;
      capA_r <= 8'hFF;
      capB_r <= 8'hFF;
      status_r <= 8'h00;
      logA_r <= 8'hFF;
      logB_r <= 8'hFF;
    end else if (clkEn) begin
      droopCnt_r <= droopTick ? 32'h0 : droopCnt_r + 32'h1;
      if (!anyOn) begin
        capA_r <= 8'hFF;
        capB_r <= 8'hFF;
      end else if (droopTick && inputLow) begin
        capA_r <= (levelA_r != 8'h00) ? levelA_r - 8'h01 : 8'h00;
        capB_r <= (levelB_r != 8'h00) ? levelB_r - 8'h01 : 8'h00;
        status_r[ftc_pkg::STATUS_DROOP] <= 1'b1;
        logA_r <= minOf(logA_r, levelA_r - 8'h01);
        logB_r <= minOf(logB_r, levelB_r - 8'h01);
      end else if (droopTick && inputRecovered && droop_r[2:0] != 3'h0) begin
        capA_r <= (capA_r < 8'hFF) ? capA_r + 8'h01 : capA_r;
        capB_r <= (capB_r < 8'hFF) ? capB_r + 8'h01 : capB_r;
      end
      if (flashPrev_r && !flashOn_r && !flashReq)
        status_r[ftc_pkg::STATUS_FTIMEOUT] <= 1'b0;
      else if (flashPrev_r && !flashOn_r)
        status_r[ftc_pkg::STATUS_FTIMEOUT] <= 1'b1;
      if (lampPrev_r && !lampOn_r && lampReq)
        status_r[ftc_pkg::STATUS_LTIMEOUT] <= 1'b1;
      // Writing the control register clears the droop flag only; a droop event wins.
      if (wrCtrl && !(droopTick && inputLow && anyOn))
        status_r[ftc_pkg::STATUS_DROOP] <= 1'b0;
    end
  end

  // Gated lamp: duty slots of 3.125% at a rate from the field.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwmDiv_r <= 8'h00;
      pwmSlot_r <= 5'h00;
    end else if (clkEn) begin
      pwmDiv_r <= pwmDiv_r + 8'h01;
      if (pwmDiv_r == (8'h0F << gated_r[7:6])) begin
        pwmDiv_r <= 8'h00;
        pwmSlot_r <= pwmSlot_r + 5'h01;
      end
    end
  end

  always_comb begin
    drive.levelA = levelA_r;
    drive.levelB = levelB_r;
    drive.onA = levelA_r != 8'h00;
    drive.onB = levelB_r != 8'h00;
    if (lampOn_r && !flashOn_r && ctrl_r[ftc_pkg::CTRL_GATED]) begin
      drive.onA = drive.onA && pwmSlot_r <= {2'h0, gated_r[5:3]};
      drive.onB = drive.onA;
    end
  end
endmodule

// ---- testbench/ftc_host.sv ----
// Host model: register bus cycles and the system signal lines.
`timescale 1ns/100ps
module ftc_host (
  input wire logic clock,
  input wire logic [7:0] rdData,
  output ftc_pkg::ftc_bus_t bus,
  output logic radioLimitPrimary,
  output logic radioLimitSecondary,
  output logic inputLow,
  output logic inputRecovered
);
  initial begin
    bus = '0;
    {radioLimitPrimary, radioLimitSecondary, inputLow, inputRecovered} = 4'h0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  // Read data stand from the cycle after the strobe until the next read.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    @(posedge clock);
    v = rdData;
  endtask
  task automatic lines(input logic [3:0] v);
    @(posedge clock);
    {radioLimitPrimary, radioLimitSecondary, inputLow, inputRecovered} <= v;
  endtask
  // Paralleled outputs get equal codes and no gating.
  task automatic pair(input logic [7:0] v);
    wr(ftc_pkg::ADDR_GATED, 8'h00);
    wr(ftc_pkg::ADDR_FLASH_A, v);
    wr(ftc_pkg::ADDR_FLASH_B, v);
  endtask
endmodule

// ---- testbench/ftc_monitor.sv ----
// Port checker for the flash and lamp current controller.
`timescale 1ns/100ps
module ftc_monitor #(
  parameter int FTIMER_LSB = 100,
  parameter int LTIMER_LSB = 100
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire ftc_pkg::ftc_bus_t bus,
  input wire logic [7:0] rdData,
  input wire logic flashTrigger,
  input wire logic lampTrigger,
  input wire logic radioLimitPrimary,
  input wire logic radioLimitSecondary,
  input wire logic inputLow,
  input wire logic inputRecovered,
  input wire ftc_pkg::ftc_drive_t drive
);
  logic [7:0] ctrl_r;
  logic [7:0] lim1_r;
  logic [7:0] lim2_r;
  logic wrOk;
  logic flashOn;
  logic lampOn;
  logic quiet;
  assign wrOk = clkEn && bus.wr;
  assign flashOn = ctrl_r[0] || ctrl_r[1] || flashTrigger;
  assign lampOn = ctrl_r[2] || ctrl_r[3] || lampTrigger;
  assign quiet = !radioLimitPrimary && !radioLimitSecondary;
  // Shadows of host writes; timeouts leave them stale, so they only gate.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r <= 8'h00;
    end else if (wrOk && bus.addr == ftc_pkg::ADDR_CTRL) begin
      ctrl_r <= bus.wdata;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lim1_r <= ftc_pkg::RST_RADIO;
      lim2_r <= ftc_pkg::RST_RADIO;
    end else if (wrOk && bus.addr == ftc_pkg::ADDR_RADIO1) begin
      lim1_r <= bus.wdata;
    end else if (wrOk && bus.addr == ftc_pkg::ADDR_RADIO2) begin
      lim2_r <= bus.wdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  reset_clear_a: assert property (disable iff (1'b0) !rst_n && clkEn
    |=> drive.levelA == 8'h00 && rdData == 8'h00)
    else $error("reset left a level or read data");
  ramp_step_a: assert property (
    $past(rst_n) && quiet && $past(quiet)
    |-> drive.levelA <= $past(drive.levelA) + 8'h02
    && drive.levelA + 8'h02 >= $past(drive.levelA))
    else $error("level jumped");
  ramp_start_a: assert property (
    $past(rst_n) && !ctrl_r[5] && $past(drive.levelA) == 8'h00
    && drive.levelA != 8'h00 |-> drive.levelA == 8'h01)
    else $error("ramp did not start at one code");
  read_back_a: assert property (
    wrOk && bus.addr == ftc_pkg::ADDR_RAMP
    ##2 clkEn && bus.rd && bus.addr == ftc_pkg::ADDR_RAMP
    |=> rdData == $past(bus.wdata, 3))
    else $error("read data wrong");
  read_hold_a: assert property (!(clkEn && bus.rd) |=> $stable(rdData))
    else $error("read data moved without a read");
  mask_first_a: assert property (
    (radioLimitPrimary && flashOn) [*5]
    |-> drive.levelA <= lim1_r && drive.levelB <= lim1_r)
    else $error("primary limit not applied");
  mask_second_a: assert property (
    (radioLimitSecondary && !radioLimitPrimary && flashOn) [*5]
    |-> drive.levelA <= lim2_r && drive.levelB <= lim2_r)
    else $error("secondary limit not applied");
  dark_off_a: assert property (drive.levelA == 8'h00 |-> !drive.onA)
    else $error("regulator on at zero level");
  no_request_a: assert property (
    !flashOn && !lampOn && !wrOk && drive.levelA == 8'h00
    |=> drive.levelA == 8'h00)
    else $error("level rose with no request");
  cover property (radioLimitPrimary && radioLimitSecondary && flashOn);
  cover property (inputLow && drive.levelA != 8'h00);
  cover property (ctrl_r[5] && drive.levelB != 8'h00);
endmodule
bind ftc_core ftc_monitor #(
  .FTIMER_LSB(FTIMER_LSB),
  .LTIMER_LSB(LTIMER_LSB)
) i_mon (
  .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .bus(bus),
  .rdData(rdData), .flashTrigger(flashTrigger),
  .lampTrigger(lampTrigger), .radioLimitPrimary(radioLimitPrimary),
  .radioLimitSecondary(radioLimitSecondary), .inputLow(inputLow),
  .inputRecovered(inputRecovered), .drive(drive)
);

// ---- testbench/flash_torch_current_ctrl_test.sv ----
// Self-checking bench for the flash and lamp current controller.
`timescale 1ns/100ps
module flash_torch_current_ctrl_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic flashTrigger = 1'b0;
  logic lampTrigger = 1'b0;
  logic limA, limB, low, rec;
  logic [7:0] rdData, d;
  ftc_pkg::ftc_bus_t bus;
  ftc_pkg::ftc_drive_t drive;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int t4, t8, n;
  always #5 clock = ~clock;
  ftc_core #(.FTIMER_LSB(100), .LTIMER_LSB(100)) i_dut (
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .bus(bus),
    .rdData(rdData), .flashTrigger(flashTrigger),
    .lampTrigger(lampTrigger), .radioLimitPrimary(limA),
    .radioLimitSecondary(limB), .inputLow(low),
    .inputRecovered(rec), .drive(drive));
  ftc_host h (.clock(clock), .rdData(rdData), .bus(bus),
    .radioLimitPrimary(limA), .radioLimitSecondary(limB),
    .inputLow(low), .inputRecovered(rec));
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clock);
  endtask
  // Returns the cycles taken for level A to reach v, or -1.
  task automatic waitA(input logic [7:0] v, input int lim, output int k);
    k = -1;
    for (int i = 0; i < lim && k < 0; i++) begin
      @(negedge clock);
      if (drive.levelA === v) k = i;
    end
  endtask
  task automatic go(input logic [7:0] c, input logic [7:0] v, input int k);
    h.wr(ftc_pkg::ADDR_CTRL, c);
    waitA(v, k, n);
    check(n >= 0, "level not reached");
  endtask
  task automatic t_regs();
    logic [7:0] e [11] = '{8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h00, 8'h11,
      8'h0F, 8'h00, 8'h10, 8'h1F, 8'h1F};
    for (int i = 0; i < 11; i++) begin
      h.rd(4'(i + 1), d);
      check(d === e[i], "reset value");
    end
    h.wr(ftc_pkg::ADDR_RAMP, 8'h5A);
    h.rd(ftc_pkg::ADDR_RAMP, d);
    check(d === 8'h5A, "readback");
    h.wr(ftc_pkg::ADDR_RAMP, ftc_pkg::RST_RAMP);
    h.wr(ftc_pkg::ADDR_STATUS, 8'hFF);
    h.rd(ftc_pkg::ADDR_STATUS, d);
    check(d === 8'h00, "status took a write");
    h.wr(ftc_pkg::ADDR_FTIMER, 8'h3F);
  endtask
  task automatic t_ramp();
    // Lamp timer off, so the priority check below sees a live lamp request.
    h.wr(ftc_pkg::ADDR_LTIMER, 8'h80);
    h.wr(ftc_pkg::ADDR_LAMP_A, 8'h20);
    h.wr(ftc_pkg::ADDR_FLASH_A, 8'h04);
    go(8'h05, 8'h04, 6000);
    t4 = n;
    idle(300);
    check(drive.levelA === 8'h04, "lamp won over flash");
    go(8'h00, 8'h00, 6000);
    h.wr(ftc_pkg::ADDR_FLASH_A, 8'h08);
    go(8'h01, 8'h08, 6000);
    t8 = n;
    check(t8 > t4 + t4 / 2 && t8 < 3 * t4, "ramp time");
    go(8'h00, 8'h00, 6000);
  endtask
  task automatic t_par();
    h.pair(8'h08);
    go(8'h23, 8'h08, 6000);
    check(n < t8 && drive.levelB === 8'h08, "parallel ramp");
    go(8'h00, 8'h00, 6000);
  endtask
  task automatic t_mask();
    h.wr(ftc_pkg::ADDR_RADIO1, 8'h02);
    h.wr(ftc_pkg::ADDR_RADIO2, 8'h05);
    go(8'h01, 8'h08, 6000);
    h.lines(4'hC);
    idle(10);
    check(drive.levelA <= 8'h02, "primary limit");
    h.lines(4'h4);
    waitA(8'h05, 3000, n);
    idle(20);
    check(n >= 0 && drive.levelA === 8'h05, "second limit");
    h.lines(4'h0);
    waitA(8'h08, 3000, n);
    check(n >= 2 * ftc_pkg::TICK_CYC, "no ramp back");
    go(8'h00, 8'h00, 6000);
  endtask
  task automatic t_droop();
    h.wr(ftc_pkg::ADDR_DROOP, 8'h11);
    go(8'h01, 8'h08, 6000);
    h.lines(4'h2);
    waitA(8'h06, 2000, n);
    h.lines(4'h1);
    check(n >= 0, "no step down");
    waitA(8'h08, 3000, n);
    idle(400);
    check(drive.levelA === 8'h08, "recovery wrong");
    h.rd(ftc_pkg::ADDR_STATUS, d);
    check(d[ftc_pkg::STATUS_DROOP] === 1'b1, "droop flag");
    h.rd(ftc_pkg::ADDR_LOG_A, d);
    check(d === 8'h06, "droop log");
    h.wr(ftc_pkg::ADDR_DROOP, 8'h10);
    h.lines(4'h2);
    waitA(8'h07, 2000, n);
    h.lines(4'h1);
    idle(500);
    check(drive.levelA === 8'h07, "rose at zero hysteresis");
    h.lines(4'h0);
    go(8'h00, 8'h00, 6000);
  endtask
  // Timer counts run from the enable write, ramp-up included.
  task automatic t_timer();
    h.wr(ftc_pkg::ADDR_FLASH_A, 8'h02);
    h.wr(ftc_pkg::ADDR_FTIMER, 8'h05);
    h.wr(ftc_pkg::ADDR_CTRL, 8'h01);
    idle(300);
    h.rd(ftc_pkg::ADDR_STATUS, d);
    check(d[1] === 1'b0, "flash timeout early");
    idle(500);
    h.rd(ftc_pkg::ADDR_STATUS, d);
    check(d[1] === 1'b1, "flash timeout");
    waitA(8'h00, 3000, n);
    check(n >= 0, "flash not ended");
    h.wr(ftc_pkg::ADDR_LAMP_A, 8'h02);
    h.wr(ftc_pkg::ADDR_LTIMER, 8'h05);
    h.wr(ftc_pkg::ADDR_CTRL, 8'h04);
    idle(800);
    h.rd(ftc_pkg::ADDR_STATUS, d);
    check(d[2] === 1'b1, "lamp timeout");
    waitA(8'h00, 3000, n);
    check(n >= 0, "lamp not ended");
    h.wr(ftc_pkg::ADDR_LTIMER, 8'h85);
    h.wr(ftc_pkg::ADDR_CTRL, 8'h00);
    go(8'h04, 8'h02, 6000);
    idle(1500);
    check(drive.levelA === 8'h02, "lamp timer ran");
    go(8'h00, 8'h00, 6000);
    h.wr(ftc_pkg::ADDR_FTIMER, 8'h7F);
    @(posedge clock) flashTrigger <= 1'b1;
    waitA(8'h02, 3000, n);
    @(posedge clock) flashTrigger <= 1'b0;
    waitA(8'h00, 3000, n);
    check(n >= 0, "level trigger ignored");
  endtask
  task automatic t_gate();
    int hi;
    hi = 0;
    h.wr(ftc_pkg::ADDR_GATED, 8'hCB);
    h.wr(ftc_pkg::ADDR_CTRL, 8'h14);
    idle(2000);
    for (int i = 0; i < 8000; i++) begin
      @(negedge clock);
      hi += int'(drive.onA === 1'b1);
    end
    check(hi > 0 && hi < 2000, "gating duty");
    go(8'h00, 8'h00, 6000);
  endtask
  // Lamp request from the pin, then a low clock enable freezes the level.
  task automatic t_freeze();
    @(posedge clock) lampTrigger <= 1'b1;
    waitA(8'h02, 3000, n);
    check(n >= 0, "lamp pin ignored");
    @(posedge clock) clkEn <= 1'b0;
    @(posedge clock) lampTrigger <= 1'b0;
    idle(500);
    check(drive.levelA === 8'h02, "level moved while frozen");
    @(posedge clock) clkEn <= 1'b1;
    waitA(8'h00, 3000, n);
    check(n >= 0, "lamp pin release ignored");
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_ramp();
    t_par();
    t_mask();
    t_droop();
    t_timer();
    t_gate();
    t_freeze();
    give_verdict();
  end
endmodule
